// file: core/ramp_pkg.sv
// package: register map, mode codes, field positions and reset values of the ramp block
package ramp_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CONTROL     = 8'h00;
	localparam logic [7:0] REG_MODE        = 8'h04;
	localparam logic [7:0] REG_STATUS      = 8'h08;
	localparam logic [7:0] REG_TARGET_VEL  = 8'h0C;
	localparam logic [7:0] REG_MIN_SPEED   = 8'h10;
	localparam logic [7:0] REG_MAX_SPEED   = 8'h14;
	localparam logic [7:0] REG_ACC_DV      = 8'h18;
	localparam logic [7:0] REG_ACC_DT      = 8'h1C;
	localparam logic [7:0] REG_DEC_DV      = 8'h20;
	localparam logic [7:0] REG_DEC_DT      = 8'h24;
	localparam logic [7:0] REG_QS_DV       = 8'h28;
	localparam logic [7:0] REG_QS_DT       = 8'h2C;
	localparam logic [7:0] REG_DIM_MUL     = 8'h30;
	localparam logic [7:0] REG_DIM_DIV     = 8'h34;
	localparam logic [7:0] REG_POLARITY    = 8'h38;
	localparam logic [7:0] REG_PROFILE     = 8'h3C;
	localparam logic [7:0] REG_MAX_PROF    = 8'h40;
	localparam logic [7:0] REG_MAX_MOTOR   = 8'h44;
	localparam logic [7:0] REG_VEL_WIN     = 8'h48;
	localparam logic [7:0] REG_VEL_WIN_T   = 8'h4C;
	localparam logic [7:0] REG_SLIP_MAX    = 8'h50;
	localparam logic [7:0] REG_SLIP_T      = 8'h54;
	localparam logic [7:0] REG_DEMAND      = 8'h58;
	localparam logic [7:0] REG_ACTUAL      = 8'h5C;
	localparam logic [7:0] REG_DEMAND_USER = 8'h60;
	localparam logic [7:0] REG_HOME_OFS    = 8'h64;
	localparam logic [7:0] REG_POS_MIN     = 8'h68;
	localparam logic [7:0] REG_POS_MAX     = 8'h6C;
	localparam logic [7:0] REG_POS_IN      = 8'h70;
	localparam logic [7:0] REG_POS_OUT     = 8'h74;
	localparam logic [7:0] REG_CYCLE       = 8'h78;
	localparam logic [31:0] UNMAPPED_VALUE = 32'hDEADBEEF;

	// ----------------------------------------------------------------
	// field positions and codes
	// ----------------------------------------------------------------
	localparam int          HALT_BIT       = 8;
	localparam int          QSTOP_BIT      = 2;
	localparam int          ENABLE_BIT     = 0;
	localparam int          CLOSED_BIT     = 1;
	localparam int          REACHED_BIT    = 10;
	localparam int          LIMIT_BIT      = 11;
	localparam int          DEVIATION_BIT  = 13;
	localparam int          POL_VEL_BIT    = 6;
	localparam logic [7:0]  MODE_VELOCITY  = 8'h02;
	localparam logic [7:0]  MODE_PROFILE   = 8'h03;
	localparam logic [7:0]  PROFILE_TRAP   = 8'h00;
	localparam logic [7:0]  PROFILE_JERK   = 8'h03;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_DIM_MUL    = 32'h00000001;
	localparam logic [31:0] RST_DIM_DIV    = 32'h00000001;
	localparam logic [31:0] RST_MAX_SPEED  = 32'h7FFFFFFF;
	localparam logic [31:0] RST_DT         = 32'h00000001;
	localparam int          CLK_HZ         = 40000000;
	localparam int          CYCLE_US       = 1000;
	localparam int          CYCLE_CLKS     = CLK_HZ / 1000000 * CYCLE_US;
	localparam int          CYCLES_PER_SEC = 1000000 / CYCLE_US;
endpackage

// file: core/window_timer.sv
// window timer: flag rises after a condition has held for a given count of control ticks
module window_timer
	import ramp_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic         tick_in,
	input  wire logic         cond_in,
	input  wire logic [W-1:0] limit_in,
	output logic              flag_out
);
	logic [W-1:0] count_q;

	// ----------------------------------------------------------------
	// counter clears as soon as the condition drops, so only an unbroken stretch counts
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_q  <= '0;
			flag_out <= 1'b0;
		end else if (!cond_in) begin
			count_q  <= '0;
			flag_out <= 1'b0;
		end else if (tick_in) begin
			if (count_q >= limit_in) begin
				flag_out <= 1'b1;
			end else begin
				count_q <= count_q + W'(1);
			end
		end
	end
endmodule

// file: core/ramp_step.sv
// ramp step: per-tick speed increment from a speed change over a time in seconds
module ramp_step
	import ramp_pkg::*;
(
	input  wire logic signed [31:0] dv_in,
	input  wire logic        [31:0] dt_in,
	output logic             [31:0] step_out
);
	logic [63:0] denom;
	logic [63:0] mag;

	// acceleration = dv / dt, spread over the control ticks of one second
	always_comb begin
		denom = 64'(dt_in) * 64'(CYCLES_PER_SEC);
		mag   = dv_in[31] ? 64'(-dv_in) : 64'(dv_in);
		if (denom == 64'h0) begin
			denom = 64'h1;
		end
		step_out = 32'(mag / denom);
		if (step_out == 32'h0 && mag != 64'h0) begin
			step_out = 32'h1; // a tiny ramp still moves instead of stalling forever
		end
	end
endmodule

// file: core/velocity_ramp_mode_control.sv
// velocity and profile velocity ramp generator with Avalon-MM register access
module velocity_ramp_mode_control
	import ramp_pkg::*;
#(
	parameter int CYCLE_CLOCKS = CYCLE_CLKS
) (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	input  wire logic [31:0] measured_speed_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic [31:0]      ramp_speed_demand_out,
	output logic             tick_out
);
	typedef enum logic [1:0] {IDLE, ANSWER} bus_state_t;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic        [15:0] control_q;
	logic        [7:0]  mode_q;
	logic        [7:0]  profile_q;
	logic signed [31:0] target_q, min_speed_q, max_speed_q;
	logic signed [31:0] acc_dv_q, dec_dv_q, qs_dv_q;
	logic        [31:0] acc_dt_q, dec_dt_q, qs_dt_q;
	logic        [31:0] dim_mul_q, dim_div_q, polarity_q;
	logic signed [31:0] max_prof_q, max_motor_q, vel_win_q, slip_max_q;
	logic        [31:0] vel_win_t_q, slip_t_q;
	logic signed [31:0] home_ofs_q, pos_min_q, pos_max_q, pos_in_q, pos_out_q;
	logic signed [31:0] demand_q;
	logic        [31:0] user_demand_q;
	logic               limit_q;
	logic        [31:0] cyc_cnt_q;
	logic               tick_q;
	bus_state_t         bus_q;
	logic        [31:0] wmask;
	logic        [31:0] rdata;

	// byte enables become a bit mask for partial writes
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
	                {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// ----------------------------------------------------------------
	// bus slave: one wait state, write lands on the released edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bus_q               <= IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h00000000;
		end else begin
			case (bus_q)
				IDLE: begin
					if (avs_read_in || avs_write_in) begin
						bus_q               <= ANSWER;
						avs_waitrequest_out <= 1'b0;
						avs_readdata_out    <= avs_read_in ? rdata : 32'h00000000;
					end
				end
				ANSWER: begin
					bus_q               <= IDLE;
					avs_waitrequest_out <= 1'b1;
				end
				default: begin
					bus_q               <= IDLE;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	logic wr;
	assign wr = avs_write_in && bus_q == ANSWER;

	// ----------------------------------------------------------------
	// host-writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control_q   <= 16'h0000;
			mode_q      <= 8'h00;
			profile_q   <= PROFILE_TRAP;
			target_q    <= '0;
			min_speed_q <= '0;
			max_speed_q <= RST_MAX_SPEED;
			acc_dv_q    <= '0;
			acc_dt_q    <= RST_DT;
			dec_dv_q    <= '0;
			dec_dt_q    <= RST_DT;
			qs_dv_q     <= '0;
			qs_dt_q     <= RST_DT;
			dim_mul_q   <= RST_DIM_MUL;
			dim_div_q   <= RST_DIM_DIV;
			polarity_q  <= '0;
			max_prof_q  <= RST_MAX_SPEED;
			max_motor_q <= RST_MAX_SPEED;
			vel_win_q   <= '0;
			vel_win_t_q <= '0;
			slip_max_q  <= RST_MAX_SPEED;
			slip_t_q    <= '0;
			home_ofs_q  <= '0;
			pos_min_q   <= '0;
			pos_max_q   <= '0;
			pos_in_q    <= '0;
		end else if (wr) begin
			case (avs_address_in)
				REG_CONTROL:    control_q   <= 16'(merge(32'(control_q), avs_writedata_in, wmask));
				REG_MODE:       mode_q      <= 8'(merge(32'(mode_q), avs_writedata_in, wmask));
				REG_TARGET_VEL: target_q    <= merge(target_q, avs_writedata_in, wmask);
				REG_MIN_SPEED:  min_speed_q <= merge(min_speed_q, avs_writedata_in, wmask);
				REG_MAX_SPEED:  max_speed_q <= merge(max_speed_q, avs_writedata_in, wmask);
				REG_ACC_DV:     acc_dv_q    <= merge(acc_dv_q, avs_writedata_in, wmask);
				REG_ACC_DT:     acc_dt_q    <= merge(acc_dt_q, avs_writedata_in, wmask);
				REG_DEC_DV:     dec_dv_q    <= merge(dec_dv_q, avs_writedata_in, wmask);
				REG_DEC_DT:     dec_dt_q    <= merge(dec_dt_q, avs_writedata_in, wmask);
				REG_QS_DV:      qs_dv_q     <= merge(qs_dv_q, avs_writedata_in, wmask);
				REG_QS_DT:      qs_dt_q     <= merge(qs_dt_q, avs_writedata_in, wmask);
				REG_DIM_MUL:    dim_mul_q   <= merge(dim_mul_q, avs_writedata_in, wmask);
				REG_DIM_DIV:    dim_div_q   <= merge(dim_div_q, avs_writedata_in, wmask);
				REG_POLARITY:   polarity_q  <= merge(polarity_q, avs_writedata_in, wmask);
				REG_PROFILE:    profile_q   <= 8'(merge(32'(profile_q), avs_writedata_in, wmask));
				REG_MAX_PROF:   max_prof_q  <= merge(max_prof_q, avs_writedata_in, wmask);
				REG_MAX_MOTOR:  max_motor_q <= merge(max_motor_q, avs_writedata_in, wmask);
				REG_VEL_WIN:    vel_win_q   <= merge(vel_win_q, avs_writedata_in, wmask);
				REG_VEL_WIN_T:  vel_win_t_q <= merge(vel_win_t_q, avs_writedata_in, wmask);
				REG_SLIP_MAX:   slip_max_q  <= merge(slip_max_q, avs_writedata_in, wmask);
				REG_SLIP_T:     slip_t_q    <= merge(slip_t_q, avs_writedata_in, wmask);
				REG_HOME_OFS:   home_ofs_q  <= merge(home_ofs_q, avs_writedata_in, wmask);
				REG_POS_MIN:    pos_min_q   <= merge(pos_min_q, avs_writedata_in, wmask);
				REG_POS_MAX:    pos_max_q   <= merge(pos_max_q, avs_writedata_in, wmask);
				REG_POS_IN:     pos_in_q    <= merge(pos_in_q, avs_writedata_in, wmask);
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control cycle tick
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cyc_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (cyc_cnt_q >= 32'(CYCLE_CLOCKS - 1)) begin
			cyc_cnt_q <= '0;
			tick_q    <= 1'b1;
		end else begin
			cyc_cnt_q <= cyc_cnt_q + 32'h1;
			tick_q    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// effective target and ramp selection
	// ----------------------------------------------------------------
	logic               vel_mode, prof_mode, halt, qstop, enable;
	logic signed [31:0] tgt_pol, tgt_mag, tgt_lim, cap, goal;
	logic               tgt_clamped;
	logic        [31:0] acc_step, dec_step, qs_step, up_step, down_step;

	assign vel_mode  = mode_q == MODE_VELOCITY;
	assign prof_mode = mode_q == MODE_PROFILE;
	assign halt      = control_q[HALT_BIT];
	assign qstop     = control_q[QSTOP_BIT];
	assign enable    = control_q[ENABLE_BIT] && (vel_mode || prof_mode);

	// min/max act on the magnitude so both directions are limited alike
	always_comb begin
		tgt_pol     = polarity_q[POL_VEL_BIT] ? -target_q : target_q;
		tgt_mag     = tgt_pol < 0 ? -tgt_pol : tgt_pol;
		tgt_clamped = 1'b0;
		cap         = (max_prof_q < max_motor_q) ? max_prof_q : max_motor_q;
		tgt_lim     = tgt_mag;
		if (vel_mode && tgt_mag != 0 && tgt_mag < min_speed_q) begin
			tgt_lim     = min_speed_q;
			tgt_clamped = 1'b1;
		end else if (vel_mode && tgt_mag > max_speed_q) begin
			tgt_lim     = max_speed_q;
			tgt_clamped = 1'b1;
		end
		if (tgt_lim > cap) begin
			tgt_lim     = cap;
			tgt_clamped = 1'b1;
		end
		goal = tgt_pol < 0 ? -tgt_lim : tgt_lim;
		if (!enable || halt || qstop) begin
			goal = '0;
		end
	end

	ramp_step acc_calc (.dv_in(acc_dv_q), .dt_in(acc_dt_q), .step_out(acc_step));
	ramp_step dec_calc (.dv_in(dec_dv_q), .dt_in(dec_dt_q), .step_out(dec_step));
	ramp_step qs_calc  (.dv_in(qs_dv_q),  .dt_in(qs_dt_q),  .step_out(qs_step));

	// jerk shaping is not modelled; type 3 is accepted in every mode and has no effect on the ramp
	assign up_step   = acc_step;
	assign down_step = qstop ? qs_step : dec_step;

	// ----------------------------------------------------------------
	// ramp generator: one step per control tick toward the goal
	// ----------------------------------------------------------------
	logic signed [31:0] demand_mag, goal_mag, diff;
	logic               speeding_up, step_limited;
	always_comb begin
		demand_mag  = demand_q < 0 ? -demand_q : demand_q;
		goal_mag    = goal < 0 ? -goal : goal;
		speeding_up = (goal_mag > demand_mag) && ((goal < 0) == (demand_q < 0) || demand_q == 0);
		diff        = goal - demand_q;
		step_limited = speeding_up ? (diff > $signed(up_step) || -diff > $signed(up_step))
		                           : (diff > $signed(down_step) || -diff > $signed(down_step));
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			demand_q <= '0;
			limit_q  <= 1'b0;
		end else if (tick_q) begin
			if (!step_limited) begin
				demand_q <= goal;
			end else if (diff > 0) begin
				demand_q <= demand_q + (speeding_up ? $signed(up_step) : $signed(down_step));
			end else begin
				demand_q <= demand_q - (speeding_up ? $signed(up_step) : $signed(down_step));
			end
			limit_q <= vel_mode && (tgt_clamped || step_limited);
		end
	end

	// ----------------------------------------------------------------
	// user-unit demand: internal rpm times divisor over multiplier
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			user_demand_q <= '0;
		end else if (tick_q) begin
			user_demand_q <= (dim_mul_q == 0) ? 32'h0 :
				32'($signed(64'(demand_q) * $signed({32'h0, dim_div_q})) /
				$signed({32'h0, dim_mul_q}));
		end
	end

	// ----------------------------------------------------------------
	// reached and deviation windows
	// ----------------------------------------------------------------
	logic signed [31:0] speed_err, slip;
	logic               in_window, slip_over, reached, deviation;
	assign speed_err = $signed(measured_speed_in) - demand_q;
	assign slip      = speed_err < 0 ? -speed_err : speed_err;
	assign in_window = prof_mode && slip <= vel_win_q && demand_q == goal;
	assign slip_over = prof_mode && control_q[CLOSED_BIT] && slip > slip_max_q;

	window_timer reach_timer (.clk_in(clk_in), .reset_n_in(reset_n_in), .tick_in(tick_q),
		.cond_in(in_window), .limit_in(vel_win_t_q), .flag_out(reached));
	window_timer slip_timer (.clk_in(clk_in), .reset_n_in(reset_n_in), .tick_in(tick_q),
		.cond_in(slip_over), .limit_in(slip_t_q), .flag_out(deviation));

	// ----------------------------------------------------------------
	// position path: home offset then modulo wrap
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pos_out_q <= '0;
		end else begin
			logic signed [31:0] p;
			logic signed [31:0] span;
			p    = pos_in_q - home_ofs_q;
			span = pos_max_q - pos_min_q + 32'sd1;
			if (pos_max_q > pos_min_q) begin
				if (p > pos_max_q) begin
					p = p - span;
				end else if (p < pos_min_q) begin
					p = p + span;
				end
			end
			pos_out_q <= p;
		end
	end

	// ----------------------------------------------------------------
	// read mux and outputs
	// ----------------------------------------------------------------
	always_comb begin
		case (avs_address_in)
			REG_CONTROL:     rdata = 32'(control_q);
			REG_MODE:        rdata = 32'(mode_q);
			REG_STATUS:      rdata = (32'(reached) << REACHED_BIT) | (32'(limit_q) << LIMIT_BIT)
			                       | (32'(deviation) << DEVIATION_BIT);
			REG_TARGET_VEL:  rdata = target_q;
			REG_MIN_SPEED:   rdata = min_speed_q;
			REG_MAX_SPEED:   rdata = max_speed_q;
			REG_ACC_DV:      rdata = acc_dv_q;
			REG_ACC_DT:      rdata = acc_dt_q;
			REG_DEC_DV:      rdata = dec_dv_q;
			REG_DEC_DT:      rdata = dec_dt_q;
			REG_QS_DV:       rdata = qs_dv_q;
			REG_QS_DT:       rdata = qs_dt_q;
			REG_DIM_MUL:     rdata = dim_mul_q;
			REG_DIM_DIV:     rdata = dim_div_q;
			REG_POLARITY:    rdata = polarity_q;
			REG_PROFILE:     rdata = 32'(profile_q);
			REG_MAX_PROF:    rdata = max_prof_q;
			REG_MAX_MOTOR:   rdata = max_motor_q;
			REG_VEL_WIN:     rdata = vel_win_q;
			REG_VEL_WIN_T:   rdata = vel_win_t_q;
			REG_SLIP_MAX:    rdata = slip_max_q;
			REG_SLIP_T:      rdata = slip_t_q;
			REG_DEMAND:      rdata = demand_q;
			REG_ACTUAL:      rdata = measured_speed_in;
			REG_DEMAND_USER: rdata = user_demand_q;
			REG_HOME_OFS:    rdata = home_ofs_q;
			REG_POS_MIN:     rdata = pos_min_q;
			REG_POS_MAX:     rdata = pos_max_q;
			REG_POS_IN:      rdata = pos_in_q;
			REG_POS_OUT:     rdata = pos_out_q;
			REG_CYCLE:       rdata = cyc_cnt_q;
			default:         rdata = UNMAPPED_VALUE;
		endcase
	end

	// demand leaves through a register so the speed loop sees a clean word
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ramp_speed_demand_out <= '0;
			tick_out              <= 1'b0;
		end else begin
			ramp_speed_demand_out <= demand_q;
			tick_out              <= tick_q;
		end
	end
endmodule

// file: testbench/velocity_ramp_mode_control_properties.sv
// checker: bus handshake, tick spacing and demand timing of the ramp block
module ramp_checker
	import ramp_pkg::*;
#(
	parameter int CYCLE_CLOCKS = CYCLE_CLKS
) (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic [31:0] ramp_speed_demand_out,
	input wire logic        tick_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	int   cnt_q;
	logic seen_q;
	// clocks since last tick; the first tick after reset has no reference
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= 0;
			seen_q <= 1'b0;
		end else if (tick_out) begin
			cnt_q <= 0;
			seen_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not answered next cycle");
	wait_idle_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
		else $error("waitrequest low without a request");
	tick_period_a: assert property (tick_out && seen_q |-> cnt_q == CYCLE_CLOCKS - 1)
		else $error("tick spacing wrong");
	tick_pulse_a: assert property (tick_out |=> !tick_out) else $error("tick too long");
	demand_tick_a: assert property ($changed(ramp_speed_demand_out)
		|-> $past(tick_out) || $past(tick_out, 2)) else $error("demand moved off tick");
	rdata_hold_a: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out)
		else $error("read data changed outside an answer");
	unmapped_read_a: assert property (avs_read_in && !avs_waitrequest_out
		&& avs_address_in > 8'h78
		|-> avs_readdata_out == UNMAPPED_VALUE) else $error("unmapped read value");
	cover property (tick_out && seen_q);
	cover property (avs_read_in && !avs_waitrequest_out && avs_address_in == REG_STATUS);
	cover property (avs_write_in && !avs_waitrequest_out);
endmodule

bind velocity_ramp_mode_control ramp_checker #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) chk_i (
	.clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_readdata_out, .avs_waitrequest_out, .ramp_speed_demand_out, .tick_out);

// file: testbench/motor_model.sv
// motor model: measured speed follows demand one clock later, optional slip offset
module motor_model (
	input  wire logic        clk_in,
	input  wire logic [31:0] demand_in,
	input  wire logic        slip_in,
	output logic      [31:0] speed_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial speed_out = 32'h00000000;
	// a slipping rotor runs 1000 above demand, well outside any small window
	always @(posedge clk_in) begin
		speed_out <= demand_in + (slip_in ? 32'h000003E8 : 32'h00000000);
	end
endmodule

// file: testbench/velocity_ramp_mode_control_bench.sv
// bench: register-level scenarios for the velocity ramp block
module velocity_ramp_mode_control_bench
	import ramp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CYC = 8;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        slip = 1'b0;
	logic [31:0] wd = 32'h00000000;
	logic [31:0] rdata, dem, spd, got;
	logic        wait_r, tick;
	int          err_total = 0;
	int          compares = 0;
	int          cycles = 0;
	// setup: caps, limits, ramps (positive dv), window, slip, velocity mode, enable
	logic [39:0] cfg [14] = '{40'h40000000C8, 40'h4400000096, 40'h1000000014, 40'h1400000078,
		40'h1800001388, 40'h2000002710, 40'h300000003C, 40'h4800000002, 40'h4C00000003,
		40'h5000000005, 40'h5400000002, 40'h0400000002, 40'h0C0000000C, 40'h0000000001};
	always #12.5 clk_in = ~clk_in;
	velocity_ramp_mode_control #(.CYCLE_CLOCKS(CYC)) dut (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hF), .measured_speed_in(spd),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
		.ramp_speed_demand_out(dem), .tick_out(tick));
	motor_model motor (.clk_in(clk_in), .demand_in(dem), .slip_in(slip), .speed_out(spd));
	task automatic results();
		if (err_total == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hang guard well above the expected run length
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			results();
		end
	end
	// one access; request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk_in); while (wait_r !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(got, exp);
	endtask
	task automatic rbit(input int b, input logic exp);
		bus(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, got[b]}, {31'h0, exp});
	endtask
	task automatic ticks(input int n);
		repeat (n * CYC) @(posedge clk_in);
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rchk(REG_DIM_MUL, RST_DIM_MUL);
		rchk(REG_MAX_SPEED, RST_MAX_SPEED);
		rchk(REG_ACC_DT, RST_DT);
		rchk(REG_PROFILE, {24'h0, PROFILE_TRAP});
		rchk(8'h7C, UNMAPPED_VALUE);
		bus(1'b1, REG_DEMAND, 32'h00000037);
		rchk(REG_DEMAND, 32'h0);
		bus(1'b1, REG_PROFILE, {24'h0, PROFILE_JERK});
		rchk(REG_PROFILE, {24'h0, PROFILE_JERK});
		foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
		rchk(REG_MODE, {24'h0, MODE_VELOCITY});
		ticks(8);
		rchk(REG_DEMAND, 32'h14);
		rbit(LIMIT_BIT, 1'b1);
		bus(1'b1, REG_TARGET_VEL, 32'h1F4);
		ticks(25);
		rchk(REG_DEMAND, 32'h78);
		rchk(REG_DEMAND_USER, 32'h2);
		rchk(REG_ACTUAL, 32'h78);
		chk(dem, 32'h78);
		bus(1'b1, REG_CONTROL, 32'h101);
		ticks(15);
		rchk(REG_DEMAND, 32'h0);
		bus(1'b1, REG_CONTROL, 32'h1);
		ticks(25);
		rchk(REG_DEMAND, 32'h78);
		bus(1'b1, REG_MODE, {24'h0, MODE_PROFILE});
		bus(1'b1, REG_TARGET_VEL, 32'h12C);
		ticks(15);
		rchk(REG_DEMAND, 32'h96);
		rbit(REACHED_BIT, 1'b1);
		bus(1'b1, REG_CONTROL, 32'h101);
		rbit(REACHED_BIT, 1'b0);
		ticks(20);
		rchk(REG_DEMAND, 32'h0);
		rbit(REACHED_BIT, 1'b1);
		slip <= 1'b1;
		bus(1'b1, REG_CONTROL, 32'h103);
		ticks(6);
		rbit(DEVIATION_BIT, 1'b1);
		slip <= 1'b0;
		bus(1'b1, REG_CONTROL, 32'h1);
		bus(1'b1, REG_POLARITY, 32'h40);
		bus(1'b1, REG_TARGET_VEL, 32'h28);
		ticks(12);
		rchk(REG_DEMAND, 32'hFFFFFFD8);
		bus(1'b1, REG_QS_DV, 32'h9C40);
		bus(1'b1, REG_CONTROL, 32'h5);
		ticks(2);
		rchk(REG_DEMAND, 32'h0);
		bus(1'b1, REG_POS_MAX, 32'h63);
		bus(1'b1, REG_HOME_OFS, 32'h0A);
		bus(1'b1, REG_POS_IN, 32'h05);
		rchk(REG_POS_OUT, 32'h5F);
		bus(1'b1, REG_POS_IN, 32'h78);
		rchk(REG_POS_OUT, 32'h0A);
		results();
	end
endmodule
